// ---- tgp_pkg.sv ----
// constants, register map and field positions for the gated timer block
package tgp_pkg;
  // register byte offsets
  localparam logic [7:0] TGP_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TGP_ADDR_GATE = 8'h04;
  localparam logic [7:0] TGP_ADDR_COUNT = 8'h08;
  localparam logic [7:0] TGP_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] TGP_ADDR_MASK = 8'h10;
  // timer_control fields
  localparam int TGP_CTRL_SRC_HI = 7;
  localparam int TGP_CTRL_SRC_LO = 6;
  localparam int TGP_CTRL_PS_HI = 5;
  localparam int TGP_CTRL_PS_LO = 4;
  localparam int TGP_CTRL_OSC = 3;
  localparam int TGP_CTRL_SYNC = 2;
  localparam int TGP_CTRL_ON = 0;
  localparam logic [7:0] TGP_CTRL_WMASK = 8'hfd;
  localparam logic [7:0] TGP_CTRL_RESET = 8'h00;
  // gate_control fields
  localparam int TGP_GATE_EN = 7;
  localparam int TGP_GATE_POL = 6;
  localparam int TGP_GATE_TGL = 5;
  localparam int TGP_GATE_SPM = 4;
  localparam int TGP_GATE_ARM = 3;
  localparam int TGP_GATE_LVL = 2;
  localparam logic [7:0] TGP_GATE_RESET = 8'h00;
  // interrupt status / mask fields
  localparam int TGP_IRQ_GATE = 0;
  localparam int TGP_IRQ_OVF = 1;
  localparam int TGP_IRQ_W = 2;
  localparam logic [TGP_IRQ_W-1:0] TGP_IRQ_RESET = 2'h0;
  // counter
  localparam int TGP_CNT_W = 16;
  localparam logic [TGP_CNT_W-1:0] TGP_CNT_RESET = 16'h0000;
  localparam logic [TGP_CNT_W-1:0] TGP_CNT_MAX = 16'hffff;
  // prescale
  localparam int TGP_PS_W = 3;
  localparam logic [1:0] TGP_PS_DIV1 = 2'h0;
  localparam logic [1:0] TGP_PS_DIV2 = 2'h1;
  localparam logic [1:0] TGP_PS_DIV4 = 2'h2;
  localparam logic [1:0] TGP_PS_DIV8 = 2'h3;
  // count clock sources
  localparam logic [1:0] TGP_SRC_SYS4 = 2'h0;
  localparam logic [1:0] TGP_SRC_SYS = 2'h1;
  localparam logic [1:0] TGP_SRC_EXT = 2'h2;
  localparam logic [1:0] TGP_SRC_OSC = 2'h3;
  localparam logic [1:0] TGP_SYS4_LAST = 2'h3;
endpackage

// ---- tgp_prescale.sv ----
// count clock prescaler: divides qualified ticks by 1, 2, 4 or 8
`timescale 1ns/100ps
module tgp_prescale
  import tgp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic tick_in,
  input wire logic [1:0] select,
  output logic tick_out
);
  logic [TGP_PS_W-1:0] div_r;

  // free divider, cleared while the timer is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= '0;
    else if (!run)
      div_r <= '0;
    else if (tick_in)
      div_r <= div_r + 3'h1;
  end

  // pass a tick once every 2^select input ticks
  always_comb
  begin
    case (select)
      TGP_PS_DIV2: tick_out = tick_in & div_r[0];
      TGP_PS_DIV4: tick_out = tick_in & (&div_r[1:0]);
      TGP_PS_DIV8: tick_out = tick_in & (&div_r);
      default: tick_out = tick_in;
    endcase
  end
endmodule // tgp_prescale

// ---- tgp_top.sv ----
// gated 16-bit timer/counter with gate measurement modes and apb registers
// Function
// - single pulse arm cleared when gate level falls
// - armed single pulse counts from gate rising edge
// - gate event flag set on gate level fall
// - sync bypass skips count clock synchroniser
// - armed counter ignores further gates until rearmed
// - toggle flip-flop on gate, held clear when off
// - polarity selects counting on high or low gate
// - gate level value valid with gate disabled
`timescale 1ns/100ps
module tgp_top
  import tgp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gate_input_pin,
  input wire logic ext_count_clock_pin,
  input wire logic osc_clock_pin,
  output logic dedicated_osc_enable,
  output logic irq
);
  logic [7:0] ctrl_r;
  logic [7:0] gate_r;
  logic [TGP_CNT_W-1:0] count_r;
  logic [TGP_IRQ_W-1:0] status_r;
  logic [TGP_IRQ_W-1:0] mask_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_prev_r;
  logic [1:0] sys4_r;
  logic gate_prev_r;
  logic tgl_r;
  logic gsrc_prev_r;
  logic sp_open_r;
  logic lvl_r;
  logic setup;
  logic wr_en;
  logic ext_lvl;
  logic raw_tick;
  logic ps_tick;
  logic pol_gate;
  logic gate_src;
  logic gate_rise;
  logic lvl;
  logic lvl_fall;
  logic count_en;
  logic overflow;
  logic [TGP_IRQ_W-1:0] events;

  // address decode shared by read and write paths
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == TGP_ADDR_CTRL) || (a == TGP_ADDR_GATE) || (a == TGP_ADDR_COUNT)
      || (a == TGP_ADDR_STATUS) || (a == TGP_ADDR_MASK);
  endfunction

  // apb handshake: answer is ready in the first access cycle
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & addr_known(paddr);
  assign pready = psel & penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;
  assign dedicated_osc_enable = ctrl_r[TGP_CTRL_OSC];

  // read data and error captured during the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_r <= ~addr_known(paddr);
      if (pwrite)
        prdata_r <= '0;
      else if (paddr == TGP_ADDR_CTRL)
        prdata_r <= {24'h0, ctrl_r};
      else if (paddr == TGP_ADDR_GATE)
        prdata_r <= {24'h0, gate_r[7:3], lvl, 2'h0};
      else if (paddr == TGP_ADDR_COUNT)
        prdata_r <= {16'h0, count_r};
      else if (paddr == TGP_ADDR_STATUS)
        prdata_r <= {30'h0, status_r};
      else if (paddr == TGP_ADDR_MASK)
        prdata_r <= {30'h0, mask_r};
      else
        prdata_r <= '0;
    end
  end

  // timer_control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= TGP_CTRL_RESET;
    else if (wr_en && paddr == TGP_ADDR_CTRL)
      ctrl_r <= pwdata[7:0] & TGP_CTRL_WMASK;
  end

  // gate control: mode bits written by software, arm bit also cleared by hardware
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_r <= TGP_GATE_RESET;
    else if (wr_en && paddr == TGP_ADDR_GATE)
      gate_r <= {pwdata[7:3], 3'h0};
    else if (gate_r[TGP_GATE_SPM] && lvl_fall)
      gate_r[TGP_GATE_ARM] <= 1'b0;
  end

  // external count pin: two-stage synchroniser plus a previous-level sample for the edge detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ctrl_r[TGP_CTRL_OSC] ? osc_clock_pin : ext_count_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_lvl;
    end
  end

  // sync bypass takes the pin straight to the edge detector
  assign ext_lvl = ctrl_r[TGP_CTRL_SYNC]
    ? (ctrl_r[TGP_CTRL_OSC] ? osc_clock_pin : ext_count_clock_pin)
    : ext_s2_r;

  // system clock divided by four for the slow internal source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys4_r <= '0;
    else
      sys4_r <= sys4_r + 2'h1;
  end

  // count clock source selection
  always_comb
  begin
    case (ctrl_r[TGP_CTRL_SRC_HI:TGP_CTRL_SRC_LO])
      TGP_SRC_SYS4: raw_tick = (sys4_r == TGP_SYS4_LAST);
      TGP_SRC_SYS: raw_tick = 1'b1;
      default: raw_tick = ext_lvl & ~ext_prev_r;
    endcase
  end

  tgp_prescale u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl_r[TGP_CTRL_ON]),
    .tick_in(raw_tick),
    .select(ctrl_r[TGP_CTRL_PS_HI:TGP_CTRL_PS_LO]),
    .tick_out(ps_tick)
  );

  // gate polarity: active level mapped to one
  assign pol_gate = gate_r[TGP_GATE_POL] ? gate_input_pin : ~gate_input_pin;

  // toggle flip-flop, held clear while toggle mode is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tgl_r <= 1'b0;
      gate_prev_r <= 1'b0;
    end
    else
    begin
      gate_prev_r <= pol_gate;
      if (!gate_r[TGP_GATE_TGL])
        tgl_r <= 1'b0;
      else if (pol_gate && !gate_prev_r)
        tgl_r <= ~tgl_r;
    end
  end

  assign gate_src = gate_r[TGP_GATE_TGL] ? tgl_r : pol_gate;
  assign gate_rise = gate_src & ~gsrc_prev_r;

  // single pulse window opens on the first rising gate edge after arming
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_open_r <= 1'b0;
      gsrc_prev_r <= 1'b0;
    end
    else
    begin
      gsrc_prev_r <= gate_src;
      if (!gate_r[TGP_GATE_ARM])
        sp_open_r <= 1'b0;
      else if (gate_rise)
        sp_open_r <= 1'b1;
    end
  end

  // gate level value, valid whether or not gating is enabled
  assign lvl = gate_r[TGP_GATE_SPM]
    ? (gate_src & (sp_open_r | (gate_r[TGP_GATE_ARM] & gate_rise)))
    : gate_src;
  assign lvl_fall = lvl_r & ~lvl;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lvl_r <= 1'b0;
    else
      lvl_r <= lvl;
  end

  // counter runs on qualified ticks while on and gate open
  assign count_en = ctrl_r[TGP_CTRL_ON] & (~gate_r[TGP_GATE_EN] | lvl);
  assign overflow = count_en & ps_tick & (count_r == TGP_CNT_MAX);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= TGP_CNT_RESET;
    else if (wr_en && paddr == TGP_ADDR_COUNT)
      count_r <= pwdata[TGP_CNT_W-1:0];
    else if (count_en && ps_tick)
      count_r <= count_r + 16'h0001;
  end

  // sticky status: hardware set wins over write-one-to-clear
  assign events = {overflow, lvl_fall};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= TGP_IRQ_RESET;
    else if (wr_en && paddr == TGP_ADDR_STATUS)
      status_r <= (status_r & ~pwdata[TGP_IRQ_W-1:0]) | events;
    else
      status_r <= status_r | events;
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= TGP_IRQ_RESET;
    else if (wr_en && paddr == TGP_ADDR_MASK)
      mask_r <= pwdata[TGP_IRQ_W-1:0];
  end

  assign irq = |(status_r & mask_r);
endmodule // tgp_top

// ---- tgp_asserts.sv ----
// bus and pin checker for the gated timer
`timescale 1ns/100ps
module tgp_asserts
  import tgp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dedicated_osc_enable,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic bad;
  logic cw;
  // access phase, unmapped address, control write
  assign acc = psel && penable;
  assign bad = paddr > TGP_ADDR_MASK || paddr[1:0] != 2'h0;
  assign cw = acc && pwrite && paddr == TGP_ADDR_CTRL;
  a_zero_wait: assert property (acc |-> pready) else $error("pready late");
  a_ready_idle: assert property (!acc |-> !pready) else $error("pready idle");
  a_err_unmapped: assert property (acc && bad |-> pslverr) else $error("no pslverr");
  a_err_mapped: assert property (acc && !bad |-> !pslverr) else $error("bad pslverr");
  a_err_idle: assert property (!acc ##1 !acc |-> !pslverr) else $error("pslverr idle");
  a_rd_unmapped: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped read data");
  a_osc_follows: assert property (cw |=> dedicated_osc_enable == $past(pwdata[3]))
    else $error("osc enable not written");
  a_osc_holds: assert property (!cw |=> $stable(dedicated_osc_enable))
    else $error("osc enable moved");
  a_irq_masked: assert property (acc && pwrite && paddr == TGP_ADDR_MASK
    && pwdata[TGP_IRQ_W-1:0] == '0 |=> !irq)
    else $error("irq with mask clear");
endmodule // tgp_asserts
bind tgp_top tgp_asserts u_tgp_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .dedicated_osc_enable, .irq);

// ---- tgp_src_model.sv ----
// far-side sources: gate level and external count clock
`timescale 1ns/100ps
module tgp_src_model
(
  input wire logic pclk,
  input wire logic gate_cmd,
  input wire logic [3:0] half,
  output logic gate_input_pin = 1'b0,
  output logic ext_count_clock_pin = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // gate follows command; count clock stands still while half is zero
  always @(posedge pclk)
  begin
    gate_input_pin <= gate_cmd;
    cnt <= (cnt + 4'h1 >= half) ? 4'h0 : cnt + 4'h1;
    if (half != 4'h0 && cnt + 4'h1 >= half)
      ext_count_clock_pin <= ~ext_count_clock_pin;
  end
endmodule // tgp_src_model

// ---- tb_timer16_gate_pulse_control.sv ----
// self-checking bench for the gated timer
`timescale 1ns/100ps
module tb_timer16_gate_pulse_control;
  import tgp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic osc_clock_pin = 1'b0;
  logic gate_cmd = 1'b0;
  logic [3:0] half = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, dedicated_osc_enable, irq;
  logic gate_input_pin, ext_count_clock_pin;
  int miscompares = 0;
  int checks_done = 0;
  int v;
  // clock and oscillator pin
  always #25 pclk = ~pclk;
  always @(posedge pclk) osc_clock_pin <= ~osc_clock_pin;
  tgp_top u_tgp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gate_input_pin, .ext_count_clock_pin, .osc_clock_pin,
    .dedicated_osc_enable, .irq);
  tgp_src_model u_tgp_src_model (.pclk, .gate_cmd, .half, .gate_input_pin,
    .ext_count_clock_pin);
  task automatic give_verdict;
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one count of slack for clock phase at start and stop
  task automatic near(input string nm, input int e);
    chk(nm, rd, (rd + 1 >= e && rd <= e + 1) ? rd : e);
  endtask
  // apb transfer, data and error taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic g(input logic lv, input int n);
    gate_cmd <= lv;
    repeat (n) @(posedge pclk);
  endtask
  // count over a 67 cycle on window
  task automatic run(input logic [7:0] c, input int e);
    apb(1, TGP_ADDR_COUNT, 32'h0);
    apb(1, TGP_ADDR_CTRL, c);
    repeat (64) @(posedge pclk);
    apb(1, TGP_ADDR_CTRL, 32'h0);
    apb(0, TGP_ADDR_COUNT, 32'h0);
    near("count", e);
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    v = $urandom(32'ha4c8496f);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 20; a += 4)
    begin
      apb(0, 8'(a), 32'h0);
      chk("reset", rd, (a == 4) ? 32'h4 : 32'h0);
      chk("slverr", err, a == 20);
    end
    apb(1, TGP_ADDR_CTRL, 32'hff);
    apb(0, TGP_ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 32'hfd);
    chk("osc", dedicated_osc_enable, 1'b1);
    apb(1, TGP_ADDR_CTRL, 32'h0);
    v = $urandom_range(16'hffff);
    apb(1, TGP_ADDR_COUNT, v);
    repeat (20) @(posedge pclk);
    apb(0, TGP_ADDR_COUNT, 32'h0);
    chk("hold", rd, v);
    for (int p = 0; p < 4; p++)
      run({2'h1, 2'(p), 4'h1}, 67 >> p);
    run(8'h01, 16);
    half <= 4'h4;
    run(8'h81, 8);
    run(8'h85, 8);
    run(8'hc1, 8);
    run(8'h89, 33);
    half <= 4'h0;
    for (int p = 0; p < 2; p++)
    begin
      apb(1, TGP_ADDR_GATE, {24'h0, 1'b1, 1'(p), 6'h0});
      g(!p, 4);
      run(8'h41, 0);
      g(p, 4);
      run(8'h41, 67);
    end
    // level with gate off, event flag, interrupt
    apb(1, TGP_ADDR_GATE, 32'h40);
    apb(1, TGP_ADDR_STATUS, 32'h3);
    apb(1, TGP_ADDR_MASK, 32'h1);
    apb(0, TGP_ADDR_GATE, 32'h0);
    chk("level", rd, 32'h44);
    g(0, 30);
    apb(0, TGP_ADDR_STATUS, 32'h0);
    chk("flag", rd, 32'h1);
    apb(1, TGP_ADDR_MASK, 32'h0);
    @(negedge pclk);
    chk("masked", irq, 1'b0);
    apb(1, TGP_ADDR_MASK, 32'h1);
    @(negedge pclk);
    chk("irq", irq, 1'b1);
    apb(1, TGP_ADDR_STATUS, 32'h1);
    @(negedge pclk);
    chk("clear", irq, 1'b0);
    // single pulse armed while gate already high
    apb(1, TGP_ADDR_GATE, 32'hd0);
    g(1, 4);
    apb(1, TGP_ADDR_GATE, 32'hd8);
    apb(1, TGP_ADDR_COUNT, 32'h0);
    apb(1, TGP_ADDR_CTRL, 32'h41);
    g(1, 20);
    apb(0, TGP_ADDR_COUNT, 32'h0);
    chk("armed", rd, 32'h0);
    g(0, 5);
    g(1, 40);
    g(0, 6);
    apb(0, TGP_ADDR_GATE, 32'h0);
    chk("done", rd, 32'hd0);
    apb(0, TGP_ADDR_COUNT, 32'h0);
    near("pulse", 40);
    v = rd;
    g(1, 20);
    g(0, 6);
    apb(0, TGP_ADDR_COUNT, 32'h0);
    chk("ignored", rd, v);
    // toggle counts rise to rise, clearing stops it
    apb(1, TGP_ADDR_GATE, 32'he0);
    apb(1, TGP_ADDR_COUNT, 32'h0);
    g(1, 3);
    g(0, 30);
    g(1, 3);
    g(0, 30);
    apb(0, TGP_ADDR_COUNT, 32'h0);
    near("toggle", 33);
    g(1, 3);
    g(0, 3);
    apb(1, TGP_ADDR_GATE, 32'hc0);
    apb(1, TGP_ADDR_GATE, 32'he0);
    apb(0, TGP_ADDR_COUNT, 32'h0);
    v = rd;
    g(0, 20);
    apb(0, TGP_ADDR_COUNT, 32'h0);
    chk("untoggle", rd, v);
    // free count wraps and sets the overflow flag
    apb(1, TGP_ADDR_GATE, 32'h0);
    apb(1, TGP_ADDR_STATUS, 32'h3);
    apb(1, TGP_ADDR_COUNT, 32'hfff0);
    repeat (20) @(posedge pclk);
    apb(0, TGP_ADDR_STATUS, 32'h0);
    chk("overflow", rd, 32'h2);
    give_verdict();
  end
endmodule // tb_timer16_gate_pulse_control
